// [include/otg_pkg.sv]
// Constants, register map and types for the overtravel stop and gear block
// Operation
// - Overtravel while running stops the motor by the selected method.
// - Low digit 0: brake and hold; 1: brake then coast; 2: coast.
// - Second digit 1: decelerate then zero clamp; 2: decelerate then coast.
// - Zero clamp holds a position loop around a zero reference.
// - Under force control never decelerate; brake or coast, then coast.
// - Emergency stop force is 0 to 800 percent, default 800, immediate.
// - Applied stopping force is clipped to the motor maximum force.
// - Enabled detector raises the overtravel warning while power is on.
// - Warning detector enable digit: 0 off by default, 1 on, immediate.
// - The warning is latched even for a momentary limit input.
// - With a reference, warn for overtravel in the commanded direction.
// - No warning for a limit opposite to the commanded direction.
// - Without a reference, either limit raises the warning.
// - No warning is detected while motor power is off.
// - Overtravel present at power on does not warn.
// - Alarm clear drops the warning regardless of power and limits; a new overtravel warning in the same cycle wins over the clear.
// - After clear during overtravel, detection waits until overtravel ends.
// - The warning never changes stop handling or blocks commands.
// - Position reference times numerator over denominator gives counts.
// - Gear terms 1 to 2^30, defaults 4 and 1, applied on restart.
// - Limit inputs are active off: off means overtravel in that direction.
// - References away from the active limit are still accepted.
package otg_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OTG_ADR_STOP   = 8'h00;
    localparam logic [7:0] OTG_ADR_ESTOP  = 8'h04;
    localparam logic [7:0] OTG_ADR_WARN   = 8'h08;
    localparam logic [7:0] OTG_ADR_GNUM   = 8'h0C;
    localparam logic [7:0] OTG_ADR_GDEN   = 8'h10;
    localparam logic [7:0] OTG_ADR_MAXF   = 8'h14;
    localparam logic [7:0] OTG_ADR_STATUS = 8'h18;
    localparam logic [7:0] OTG_ADR_CMD    = 8'h1C;
    // ----------------------------------------------------------------
    // Reset values and ranges
    // ----------------------------------------------------------------
    localparam logic [7:0]  OTG_STOP_RST  = 8'h00;
    localparam logic [9:0]  OTG_ESTOP_MAX = 10'h320;
    localparam logic [9:0]  OTG_ESTOP_RST = 10'h320;
    localparam logic [9:0]  OTG_MAXF_RST  = 10'h12C;
    localparam logic [3:0]  OTG_WARN_RST  = 4'h0;
    localparam logic [30:0] OTG_GNUM_RST  = 31'h0000_0004;
    localparam logic [30:0] OTG_GDEN_RST  = 31'h0000_0001;
    localparam logic [30:0] OTG_GEAR_MAX  = 31'h4000_0000;
    localparam logic [11:0] OTG_WARN_CODE = 12'h9A0;
    // ----------------------------------------------------------------
    // Field positions and codes
    // ----------------------------------------------------------------
    localparam int          OTG_WARN_LSB  = 12;
    localparam int          OTG_CMD_CLR   = 0;
    localparam int          OTG_CMD_RST   = 1;
    localparam logic [3:0]  OTG_LOW_DB    = 4'h0;
    localparam logic [3:0]  OTG_LOW_DBC   = 4'h1;
    localparam logic [3:0]  OTG_MID_ZC    = 4'h1;
    localparam logic [3:0]  OTG_MID_DC    = 4'h2;
    localparam logic [3:0]  OTG_WARN_ON   = 4'h1;

    typedef enum logic [2:0] {
        ST_RUN, ST_DB, ST_COAST, ST_DECEL, ST_HOLD_DB, ST_HOLD_CO, ST_HOLD_ZC
    } otg_stop_t;
endpackage

// [logic/otg_overtravel_gear.sv]
// Overtravel stop sequencer, warning detector and electronic gear
`timescale 1ns/1ps
module otg_overtravel_gear
    import otg_pkg::*;
#(
    parameter int REF_W = 32
)(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // Limit pins, active off
    input  wire logic             fwd_limit_in_i,
    input  wire logic             rev_limit_in_i,
    // Drive state
    input  wire logic             power_on_i,
    input  wire logic             running_i,
    input  wire logic             stopped_i,
    input  wire logic             force_ctrl_i,
    input  wire logic             ref_fwd_i,
    input  wire logic             ref_rev_i,
    // Stop outputs
    output logic                  dynamic_brake_o,
    output logic                  coast_o,
    output logic                  decel_o,
    output logic                  zero_clamp_o,
    output logic      [9:0]       stop_force_o,
    output logic                  fwd_inhibit_o,
    output logic                  rev_inhibit_o,
    output logic                  ot_warn_o,
    // Position reference gear
    input  wire logic [REF_W-1:0] pos_ref_i,
    input  wire logic             pos_ref_valid_i,
    output logic      [REF_W-1:0] pos_cnt_o,
    output logic                  pos_cnt_valid_o,
    output logic                  pos_busy_o
);
    localparam int         PW    = REF_W + 31;
    localparam logic [6:0] STEPS = 7'(PW);
    // ----------------------------------------------------------------
    // Registers and bus decode
    // ----------------------------------------------------------------
    logic [7:0]  stop_cfg_r, stop_act_r;
    logic [9:0]  estop_r, maxf_r;
    logic [3:0]  warn_cfg_r;
    logic [30:0] gnum_cfg_r, gden_cfg_r, gnum_act_r, gden_act_r;
    logic        ack_r, wr, clr, restart, gear_ok;
    logic [31:0] dat_r, rd_mux, wmask, wv;
    // Byte lane mask
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // Write takes effect at the edge the master sees ack
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
    assign clr = wr && wb_adr_i == OTG_ADR_CMD && wb_sel_i[0] && wb_dat_i[OTG_CMD_CLR];
    assign restart = wr && wb_adr_i == OTG_ADR_CMD && wb_sel_i[0] && wb_dat_i[OTG_CMD_RST];
    // Gear terms outside 1 to 2^30 are refused
    assign gear_ok = wv[31] == 1'b0 && wv[30:0] != 31'h0 && wv[30:0] <= OTG_GEAR_MAX;
    // ----------------------------------------------------------------
    // Limit synchronisers
    // ----------------------------------------------------------------
    logic [1:0] fwd_sync_r, rev_sync_r;
    logic       fwd_ot_d_r, rev_ot_d_r, fwd_ot, rev_ot;
    // Two stages per pin, reset to permitted level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fwd_sync_r <= 2'h3;
            rev_sync_r <= 2'h3;
            fwd_ot_d_r <= 1'b0;
            rev_ot_d_r <= 1'b0;
        end else begin
            fwd_sync_r <= {fwd_sync_r[0], fwd_limit_in_i};
            rev_sync_r <= {rev_sync_r[0], rev_limit_in_i};
            fwd_ot_d_r <= fwd_ot;
            rev_ot_d_r <= rev_ot;
        end
    end
    // Off level means overtravel
    assign fwd_ot = ~fwd_sync_r[1];
    assign rev_ot = ~rev_sync_r[1];
    // Current merge of old and written value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [31:0] m);
        merge = (old & ~m) | (d & m);
    endfunction
    // Configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stop_cfg_r <= OTG_STOP_RST;
            estop_r    <= OTG_ESTOP_RST;
            maxf_r     <= OTG_MAXF_RST;
            warn_cfg_r <= OTG_WARN_RST;
            gnum_cfg_r <= OTG_GNUM_RST;
            gden_cfg_r <= OTG_GDEN_RST;
        end else if (wr) begin
            case (wb_adr_i)
                OTG_ADR_STOP:  stop_cfg_r <= wv[7:0];
                OTG_ADR_ESTOP: begin
                    // Values above range saturate
                    estop_r <= (wv[9:0] > OTG_ESTOP_MAX) ? OTG_ESTOP_MAX : wv[9:0];
                end
                OTG_ADR_MAXF:  maxf_r <= wv[9:0];
                OTG_ADR_WARN:  warn_cfg_r <= wv[OTG_WARN_LSB+:4];
                // Out of range writes are ignored
                OTG_ADR_GNUM:  if (gear_ok) gnum_cfg_r <= wv[30:0];
                OTG_ADR_GDEN:  if (gear_ok) gden_cfg_r <= wv[30:0];
                default: ;
            endcase
        end
    end
    // Old value of addressed register for byte merge
    assign wv = merge(rd_mux, wb_dat_i, wmask);
    // Settings that apply only on restart
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stop_act_r <= OTG_STOP_RST;
            gnum_act_r <= OTG_GNUM_RST;
            gden_act_r <= OTG_GDEN_RST;
        end else if (restart) begin
            stop_act_r <= stop_cfg_r;
            gnum_act_r <= gnum_cfg_r;
            gden_act_r <= gden_cfg_r;
        end
    end

    // ----------------------------------------------------------------
    // Stop sequencer
    // ----------------------------------------------------------------
    otg_stop_t   state_r, state_nxt;
    logic        away_f, away_r, trig, leave, use_decel;
    logic [3:0]  low_dig, mid_dig;
    logic [9:0]  force_lim;
    assign low_dig = stop_act_r[3:0];
    assign mid_dig = stop_act_r[7:4];
    // Motion commanded away from the active limit
    assign away_f = ref_rev_i & ~ref_fwd_i;
    assign away_r = ref_fwd_i & ~ref_rev_i;
    assign trig = running_i & power_on_i & ((fwd_ot & ~away_f) | (rev_ot & ~away_r));
    assign leave = ~power_on_i | ~(fwd_ot | rev_ot) | (fwd_ot & away_f) | (rev_ot & away_r);
    // Force control never decelerates
    assign use_decel = ~force_ctrl_i && (mid_dig == OTG_MID_ZC || mid_dig == OTG_MID_DC);
    assign force_lim = (estop_r < maxf_r) ? estop_r : maxf_r;

    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (trig) begin
                    if (use_decel) begin
                        state_nxt = ST_DECEL;
                    end else if (low_dig == OTG_LOW_DB || low_dig == OTG_LOW_DBC) begin
                        state_nxt = ST_DB;
                    end else begin
                        state_nxt = ST_COAST;
                    end
                end
            end
            ST_DB: begin
                if (leave) begin
                    state_nxt = ST_RUN;
                end else if (stopped_i) begin
                    // Hold braking only for code 0 outside force control
                    if (low_dig == OTG_LOW_DB && !force_ctrl_i) begin
                        state_nxt = ST_HOLD_DB;
                    end else begin
                        state_nxt = ST_HOLD_CO;
                    end
                end
            end
            ST_COAST: begin
                if (leave) begin
                    state_nxt = ST_RUN;
                end else if (stopped_i) begin
                    state_nxt = ST_HOLD_CO;
                end
            end
            ST_DECEL: begin
                if (leave) begin
                    state_nxt = ST_RUN;
                end else if (stopped_i) begin
                    if (mid_dig == OTG_MID_ZC) begin
                        state_nxt = ST_HOLD_ZC;
                    end else begin
                        state_nxt = ST_HOLD_CO;
                    end
                end
            end
            ST_HOLD_DB, ST_HOLD_CO, ST_HOLD_ZC: begin
                if (leave) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Stop outputs, aligned with the state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dynamic_brake_o <= 1'b0;
            coast_o         <= 1'b0;
            decel_o         <= 1'b0;
            zero_clamp_o    <= 1'b0;
            stop_force_o    <= 10'h000;
            fwd_inhibit_o   <= 1'b0;
            rev_inhibit_o   <= 1'b0;
        end else begin
            dynamic_brake_o <= state_nxt == ST_DB || state_nxt == ST_HOLD_DB;
            coast_o         <= state_nxt == ST_COAST || state_nxt == ST_HOLD_CO;
            decel_o         <= state_nxt == ST_DECEL;
            // Position loop closed on a zero reference
            zero_clamp_o    <= state_nxt == ST_HOLD_ZC;
            stop_force_o    <= (state_nxt == ST_DECEL) ? force_lim : 10'h000;
            fwd_inhibit_o   <= fwd_ot;
            rev_inhibit_o   <= rev_ot;
        end
    end

    // ----------------------------------------------------------------
    // Overtravel warning
    // ----------------------------------------------------------------
    logic warn_en, fwd_new, rev_new, hit, warn_r;
    assign warn_en = warn_cfg_r == OTG_WARN_ON;
    // New overtravel only; a level held across power on or clear is ignored
    assign fwd_new = fwd_ot & ~fwd_ot_d_r;
    assign rev_new = rev_ot & ~rev_ot_d_r;
    assign hit = warn_en & power_on_i & ((fwd_new & ~away_f) | (rev_new & ~away_r));

    // Sticky warning, set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            warn_r <= 1'b0;
        end else if (hit) begin
            warn_r <= 1'b1;
        end else if (clr) begin
            warn_r <= 1'b0;
        end
    end

    // Warning flag output, stop logic never reads it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ot_warn_o <= 1'b0;
        end else begin
            ot_warn_o <= warn_r;
        end
    end

    // ----------------------------------------------------------------
    // Electronic gear divider
    // ----------------------------------------------------------------
    logic [PW-1:0]    quo_r;
    logic [30:0]      rem_r;
    logic [6:0]       cnt_r;
    logic             neg_r, ge;
    logic [31:0]      trial;
    logic [REF_W-1:0] mag;
    assign mag = pos_ref_i[REF_W-1] ? REF_W'(-pos_ref_i) : pos_ref_i;
    assign trial = {rem_r, quo_r[PW-1]};
    assign ge = trial >= {1'b0, gden_act_r};

    // Multiply, then restoring divide one bit per cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            quo_r           <= '0;
            rem_r           <= 31'h0;
            cnt_r           <= 7'h00;
            neg_r           <= 1'b0;
            pos_busy_o      <= 1'b0;
            pos_cnt_o       <= '0;
            pos_cnt_valid_o <= 1'b0;
        end else begin
            pos_cnt_valid_o <= 1'b0;
            if (!pos_busy_o) begin
                if (pos_ref_valid_i) begin
                    quo_r      <= PW'(mag) * PW'(gnum_act_r);
                    rem_r      <= 31'h0;
                    neg_r      <= pos_ref_i[REF_W-1];
                    cnt_r      <= STEPS;
                    pos_busy_o <= 1'b1;
                end
            end else if (cnt_r != 7'h00) begin
                rem_r <= ge ? 31'(trial - {1'b0, gden_act_r}) : trial[30:0];
                quo_r <= {quo_r[PW-2:0], ge};
                cnt_r <= cnt_r - 7'h01;
            end else begin
                pos_cnt_o       <= neg_r ? REF_W'(-quo_r[REF_W-1:0]) : quo_r[REF_W-1:0];
                pos_cnt_valid_o <= 1'b1;
                pos_busy_o      <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus read and acknowledge
    // ----------------------------------------------------------------
    // Read mux, unmapped reads zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            OTG_ADR_STOP:  rd_mux[7:0] = stop_cfg_r;
            OTG_ADR_ESTOP: rd_mux[9:0] = estop_r;
            OTG_ADR_MAXF:  rd_mux[9:0] = maxf_r;
            OTG_ADR_WARN:  rd_mux[OTG_WARN_LSB+:4] = warn_cfg_r;
            OTG_ADR_GNUM:  rd_mux[30:0] = gnum_cfg_r;
            OTG_ADR_GDEN:  rd_mux[30:0] = gden_cfg_r;
            OTG_ADR_STATUS: begin
                rd_mux[0]     = warn_r;
                rd_mux[1]     = fwd_ot;
                rd_mux[2]     = rev_ot;
                rd_mux[6:4]   = state_r;
                rd_mux[8]     = pos_busy_o;
                rd_mux[27:16] = warn_r ? OTG_WARN_CODE : 12'h000;
            end
            default: begin
            end
        endcase
    end

    // One cycle ack, read data captured with it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
            dat_r <= rd_mux;
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence decel_done_s;
        state_r == ST_DECEL && stopped_i && !leave;
    endsequence
    sequence fwd_warn_s;
        warn_en && power_on_i && fwd_new && !away_f;
    endsequence

    warn_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fwd_warn_s |=> warn_r ##1 ot_warn_o)
        else $error("overtravel warning not raised");
    warn_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !warn_en && !warn_r |=> !warn_r)
        else $error("warning raised while disabled");
    warn_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        warn_r && !clr |=> warn_r)
        else $error("held warning dropped without clear");
    opp_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
        away_r && !fwd_new && !warn_r |=> !warn_r)
        else $error("warning for limit opposite to reference");
    power_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !power_on_i && !warn_r |=> !warn_r)
        else $error("warning raised with power off");
    warn_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        clr && !hit |=> !warn_r ##1 !ot_warn_o)
        else $error("alarm clear did not drop warning");
    force_clip_a: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_force_o <= maxf_r || $past(maxf_r) >= stop_force_o)
        else $error("stop force above motor maximum");
    estop_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
        estop_r <= OTG_ESTOP_MAX)
        else $error("emergency stop force out of range");
    zero_clamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
        decel_done_s ##0 mid_dig == OTG_MID_ZC |=> state_r == ST_HOLD_ZC ##0 zero_clamp_o)
        else $error("zero clamp not entered after decel");
    force_ctl_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_r == ST_RUN && trig && force_ctrl_i |=> state_r inside {ST_DB, ST_COAST})
        else $error("decel used under force control");
    gear_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !pos_busy_o && pos_ref_valid_i |=> pos_busy_o ##[1:70] pos_cnt_valid_o)
        else $error("gear result late");
endmodule

// [verif/otg_motor_model.sv]
// Motor model that slows to rest once a stop action acts
`timescale 1ns/1ps
module otg_motor_model (
    input  wire logic clk_i,
    input  wire logic stop_act_i,
    output logic      running_o,
    output logic      stopped_o
);
    logic [1:0] cnt_r;
    // Speed decays over three cycles while any stop acts
    always_ff @(posedge clk_i) begin
        if (!stop_act_i) cnt_r <= 2'h0;
        else if (cnt_r != 2'h3) cnt_r <= cnt_r + 2'h1;
    end
    assign running_o = (cnt_r != 2'h3);
    assign stopped_o = (cnt_r == 2'h3);
endmodule

// [verif/overtravel_stop_and_gear_tb.sv]
// Testbench for the overtravel stop and gear block
`timescale 1ns/1ps
module overtravel_stop_and_gear_tb;
    import otg_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, pv = 0, pcv, pb;
    logic        fwd = 1, rev = 1, pwr = 0, fc = 0, rf = 0, rr = 0, run, stp;
    logic        db, co, dc, zc, fi, ri, wo;
    logic [7:0]  adr = 8'h00;
    logic [9:0]  sf;
    logic [31:0] dat = 32'h0, rdat, q, pref = 32'h0, pcnt;
    int          num_errors = 0, cmp_count = 0, cyc_n = 0;
    otg_overtravel_gear dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .fwd_limit_in_i(fwd), .rev_limit_in_i(rev), .power_on_i(pwr),
        .running_i(run), .stopped_i(stp), .force_ctrl_i(fc), .ref_fwd_i(rf),
        .ref_rev_i(rr), .dynamic_brake_o(db), .coast_o(co), .decel_o(dc),
        .zero_clamp_o(zc), .stop_force_o(sf), .fwd_inhibit_o(fi), .rev_inhibit_o(ri),
        .ot_warn_o(wo), .pos_ref_i(pref), .pos_ref_valid_i(pv), .pos_cnt_o(pcnt),
        .pos_cnt_valid_o(pcv), .pos_busy_o(pb));
    otg_motor_model mot (.clk_i(clk), .stop_act_i(db | co | dc | zc), .running_o(run),
        .stopped_o(stp));
    always #5 clk = ~clk;
    // Cycle ceiling against a hang
    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chw(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chb(input logic g, input logic e);
        chw({31'h0, g}, {31'h0, e});
    endtask
    task automatic w(input int k);
        repeat (k) @(posedge clk);
    endtask
    // Classic cycle, held until ack is sampled
    task automatic wb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr_en;
        adr <= a;
        dat <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chw(q, e);
    endtask
    task automatic gear(input logic [31:0] r, input logic [31:0] e);
        pref <= r;
        pv <= 1'b1;
        @(posedge clk);
        pv <= 1'b0;
        while (pcv !== 1'b1) @(posedge clk);
        chw(pcnt, e);
    endtask
    // Main sequence
    initial begin
        w(12);
        rst <= 1'b0;
        @(posedge clk);
        rd(OTG_ADR_ESTOP, 32'h0000_0320);
        rd(OTG_ADR_GNUM, 32'h0000_0004);
        rd(OTG_ADR_GDEN, 32'h0000_0001);
        rd(OTG_ADR_WARN, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        gear(32'h0000_000A, 32'h0000_0028);
        $display("test defaults done");
        pwr <= 1'b1;
        w(4);
        fwd <= 1'b0;
        w(12);
        chb(db, 1'b1);
        chb(co, 1'b0);
        chb(fi, 1'b1);
        rd(OTG_ADR_STATUS, 32'h0000_0042);
        rr <= 1'b1;
        w(6);
        chb(db, 1'b0);
        fwd <= 1'b1;
        w(6);
        rr <= 1'b0;
        wr(OTG_ADR_STOP, 32'h0000_0010);
        wr(OTG_ADR_CMD, 32'h0000_0002);
        wr(OTG_ADR_ESTOP, 32'h0000_0384);
        rd(OTG_ADR_ESTOP, 32'h0000_0320);
        rev <= 1'b0;
        while (dc !== 1'b1) @(posedge clk);
        chw({22'h0, sf}, 32'h0000_012C);
        chb(ri, 1'b1);
        w(10);
        chb(zc, 1'b1);
        rev <= 1'b1;
        w(8);
        wr(OTG_ADR_STOP, 32'h0000_0021);
        wr(OTG_ADR_CMD, 32'h0000_0002);
        fc <= 1'b1;
        fwd <= 1'b0;
        w(4);
        chb(db, 1'b1);
        chb(dc, 1'b0);
        w(8);
        chb(co, 1'b1);
        chb(db, 1'b0);
        fwd <= 1'b1;
        fc <= 1'b0;
        w(8);
        fwd <= 1'b0;
        w(4);
        chb(dc, 1'b1);
        w(8);
        chb(co, 1'b1);
        fwd <= 1'b1;
        w(8);
        wr(OTG_ADR_STOP, 32'h0000_0002);
        wr(OTG_ADR_CMD, 32'h0000_0002);
        fwd <= 1'b0;
        w(4);
        chb(co, 1'b1);
        chb(db, 1'b0);
        fwd <= 1'b1;
        w(8);
        $display("test stop done");
        wr(OTG_ADR_WARN, 32'h0000_1000);
        rf <= 1'b1;
        rev <= 1'b0;
        w(3);
        rev <= 1'b1;
        w(10);
        chb(wo, 1'b0);
        rf <= 1'b0;
        fwd <= 1'b0;
        w(3);
        fwd <= 1'b1;
        w(12);
        chb(wo, 1'b1);
        rd(OTG_ADR_STATUS, 32'h09A0_0001);
        wr(OTG_ADR_CMD, 32'h0000_0001);
        w(3);
        chb(wo, 1'b0);
        pwr <= 1'b0;
        fwd <= 1'b0;
        w(8);
        chb(wo, 1'b0);
        pwr <= 1'b1;
        w(8);
        chb(wo, 1'b0);
        fwd <= 1'b1;
        w(8);
        rf <= 1'b1;
        fwd <= 1'b0;
        w(6);
        chb(wo, 1'b1);
        wr(OTG_ADR_CMD, 32'h0000_0001);
        w(6);
        chb(wo, 1'b0);
        fwd <= 1'b1;
        rf <= 1'b0;
        w(8);
        $display("test warning done");
        wr(OTG_ADR_GNUM, 32'h0000_0003);
        wr(OTG_ADR_GDEN, 32'h0000_0002);
        wr(OTG_ADR_GNUM, 32'h0000_0000);
        rd(OTG_ADR_GNUM, 32'h0000_0003);
        wr(OTG_ADR_CMD, 32'h0000_0002);
        gear(32'hFFFF_FFF9, 32'hFFFF_FFF6);
        chb(pb, 1'b0);
        $display("test gear done");
        print_verdict();
    end
endmodule
